// File: include/rscs_pkg.sv
// reset source combiner: register map, field positions, reset values
// assumes a 32-bit AXI4-Lite slave port and one system clock
package rscs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0]  ADDR_CAUSE   = 8'h00;
    localparam logic [7:0]  ADDR_BACKUP  = 8'h04;
    localparam logic [7:0]  ADDR_LIVE    = 8'h08;

    ////////////////////////////////////////////////////////////////////////////////
    // reset_cause_control field positions
    localparam int BIT_TRAP   = 15;
    localparam int BIT_BADOP  = 14;
    localparam int BIT_LVHOLD = 12;
    localparam int BIT_DEEP   = 10;
    localparam int BIT_CFGMIS = 9;
    localparam int BIT_FBIAS  = 8;
    localparam int BIT_PIN    = 7;
    localparam int BIT_INSTR  = 6;
    localparam int BIT_SWDT   = 5;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG   = 4;
    localparam int BIT_SLEEP  = 3;
    localparam int BIT_IDLE   = 2;
    localparam int BIT_BOR    = 1;
    localparam int BIT_POR    = 0;

    localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
    localparam logic [15:0] CAUSE_IMPL    = 16'hD7FF;

    ////////////////////////////////////////////////////////////////////////////////
    // backup_reset_status fields
    localparam int          BIT_BK_RST    = 0;
    localparam int          BIT_BK_POR    = 1;
    localparam logic [1:0]  BACKUP_POR_VAL = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // live status fields
    localparam int BIT_LV_RST  = 0;
    localparam int BIT_LV_WDT  = 1;
    localparam int BIT_LV_RET  = 2;
    localparam int BIT_LV_BIAS = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // reset source vector indices
    localparam int SRC_PIN   = 0;
    localparam int SRC_INSTR = 1;
    localparam int SRC_WDT   = 2;
    localparam int SRC_BOR   = 3;
    localparam int SRC_CFGM  = 4;
    localparam int SRC_TRAP  = 5;
    localparam int SRC_ILLOP = 6;
    localparam int SRC_UWR   = 7;
    localparam int NSRC      = 8;

    // extra cycles the combined reset stays low after the last source drops
    localparam int RST_HOLD_CYC = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: rtl/rscs_src_merge.sv
// reset source merge: or of all requests, stretched, registered
// assumes requests are synchronous to aclk; power-on comes in as aresetn
`timescale 1ns/1ps
module rscs_src_merge #(
    parameter int NSRC     = 8,
    parameter int HOLD_CYC = 1
) (
    // clock and power-on reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // requests
    input  wire logic [NSRC-1:0] src_req,
    // merged result
    output logic                 any_active_q,
    output logic [NSRC-1:0]      src_seen_q
);

    localparam int CW = $clog2(HOLD_CYC + 1) + 1;

    logic [CW-1:0] hold_q;
    logic          any_req;

    assign any_req = |src_req;

    ////////////////////////////////////////////////////////////////////////////////
    // the merged reset stays active a few cycles so a one-cycle pulse still
    // reaches every register it must clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q       <= '0;
            any_active_q <= 1'b1;
        end else if (any_req) begin
            hold_q       <= CW'(HOLD_CYC);
            any_active_q <= 1'b1;
        end else if (hold_q != '0) begin
            hold_q       <= hold_q - CW'(1);
            any_active_q <= 1'b1;
        end else begin
            any_active_q <= 1'b0;
        end
    end

    // one-cycle record of which sources fired, for the cause flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_seen_q <= '0;
        end else begin
            src_seen_q <= src_req;
        end
    end

endmodule

// File: rtl/rscs_top.sv
// reset source combiner with cause/control register over AXI4-Lite
// assumes all request and event inputs are synchronous one-bit levels or pulses
// on aclk, and that aresetn low is the power-on reset
`timescale 1ns/1ps

module rscs_top #(
    parameter int AW       = 8,
    parameter int HOLD_CYC = rscs_pkg::RST_HOLD_CYC
) (
    // clock and power-on reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // axi4-lite write address
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    // axi4-lite write response
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // axi4-lite read address
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    // axi4-lite read data
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // reset requests
    input  wire logic          master_clear_pin,
    input  wire logic          instr_reset_req,
    input  wire logic          watchdog_timeout,
    input  wire logic          brownout_reset,
    input  wire logic          config_mismatch_req,
    input  wire logic          trap_conflict_req,
    input  wire logic          illegal_opcode_req,
    input  wire logic          uninit_wreg_reset,
    // power-save events from the core
    input  wire logic          pwrsav_sleep,
    input  wire logic          pwrsav_idle,
    input  wire logic          deep_sleep_en,
    input  wire logic          watchdog_clear,
    input  wire logic          backup_power_active,
    // configuration fuses
    input  wire logic          low_power_cfg_fuse,
    input  wire logic          fuse_watchdog_on,
    // outputs
    output logic               master_system_reset_n,
    output logic               watchdog_enabled,
    output logic               retention_hold_on,
    output logic               flash_bias_in_standby
);

    ////////////////////////////////////////////////////////////////////////////////
    // source merge

    logic [rscs_pkg::NSRC-1:0] src_req;
    logic [rscs_pkg::NSRC-1:0] src_seen_q;
    logic                      any_active_q;

    always_comb begin
        src_req                       = '0;
        src_req[rscs_pkg::SRC_PIN]    = master_clear_pin;
        src_req[rscs_pkg::SRC_INSTR]  = instr_reset_req;
        src_req[rscs_pkg::SRC_WDT]    = watchdog_timeout;
        src_req[rscs_pkg::SRC_BOR]    = brownout_reset;
        src_req[rscs_pkg::SRC_CFGM]   = config_mismatch_req;
        src_req[rscs_pkg::SRC_TRAP]   = trap_conflict_req;
        src_req[rscs_pkg::SRC_ILLOP]  = illegal_opcode_req;
        src_req[rscs_pkg::SRC_UWR]    = uninit_wreg_reset;
    end

    // power-on enters through aresetn, the other sources through src_req
    rscs_src_merge #(
        .NSRC     (rscs_pkg::NSRC),
        .HOLD_CYC (HOLD_CYC)
    ) u_merge (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .src_req      (src_req),
        .any_active_q (any_active_q),
        .src_seen_q   (src_seen_q)
    );

    assign master_system_reset_n = ~any_active_q;

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write path: address and data taken in either order

    logic [AW-1:0] aw_addr_q;
    logic          aw_full_q;
    logic [31:0]   w_data_q;
    logic [3:0]    w_strb_q;
    logic          w_full_q;
    logic          bvalid_q;
    logic [1:0]    bresp_q;
    logic          wr_go;
    logic          wr_hit_cause;
    logic          wr_hit_backup;

    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready  = ~w_full_q;
    assign wr_go         = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_hit_cause  = wr_go && (aw_addr_q == rscs_pkg::ADDR_CAUSE);
    assign wr_hit_backup = wr_go && (aw_addr_q == rscs_pkg::ADDR_BACKUP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_full_q <= 1'b0;
        end
    end

    // the live register is read-only; writes to it answer okay and are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= rscs_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            if (wr_hit_cause || wr_hit_backup || aw_addr_q == rscs_pkg::ADDR_LIVE) begin
                bresp_q <= rscs_pkg::RESP_OKAY;
            end else begin
                bresp_q <= rscs_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // byte lanes 0 and 1 carry the 16-bit register
    logic [15:0] wr_mask;
    assign wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    ////////////////////////////////////////////////////////////////////////////////
    // reset_cause_control bit events

    logic [15:0] cause_q;
    logic [15:0] hw_set;
    logic [15:0] hw_clr;
    logic [15:0] sw_we;

    always_comb begin
        hw_set                       = '0;
        hw_set[rscs_pkg::BIT_TRAP]   = src_seen_q[rscs_pkg::SRC_TRAP];
        hw_set[rscs_pkg::BIT_BADOP]  = src_seen_q[rscs_pkg::SRC_ILLOP]
                                     | src_seen_q[rscs_pkg::SRC_UWR];
        hw_set[rscs_pkg::BIT_DEEP]   = pwrsav_sleep & deep_sleep_en;
        hw_set[rscs_pkg::BIT_CFGMIS] = src_seen_q[rscs_pkg::SRC_CFGM];
        hw_set[rscs_pkg::BIT_PIN]    = src_seen_q[rscs_pkg::SRC_PIN];
        hw_set[rscs_pkg::BIT_INSTR]  = src_seen_q[rscs_pkg::SRC_INSTR];
        hw_set[rscs_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]   = src_seen_q[rscs_pkg::SRC_WDT];
        hw_set[rscs_pkg::BIT_SLEEP]  = pwrsav_sleep;
        hw_set[rscs_pkg::BIT_IDLE]   = pwrsav_idle;
        hw_set[rscs_pkg::BIT_BOR]    = src_seen_q[rscs_pkg::SRC_BOR];
    end

    always_comb begin
        hw_clr                     = '0;
        // watchdog clear and either power-save entry drop the timeout flag
        hw_clr[rscs_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = watchdog_clear | pwrsav_sleep | pwrsav_idle;
    end

    assign sw_we = wr_hit_cause ? wr_mask : 16'h0000;

    // every implemented bit: power-on value, then hardware set, then software, then clear.
    // flags and control bits live only here, so a software set can never feed
    // back into the source merge
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_cause
            if (rscs_pkg::CAUSE_IMPL[gi]) begin : g_impl
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        cause_q[gi] <= rscs_pkg::CAUSE_POR_VAL[gi];
                    end else if (hw_set[gi]) begin
                        cause_q[gi] <= 1'b1;
                    end else if (sw_we[gi]) begin
                        cause_q[gi] <= w_data_q[gi];
                    end else if (hw_clr[gi]) begin
                        cause_q[gi] <= 1'b0;
                    end
                end
            end else begin : g_none
                assign cause_q[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // backup_reset_status: resets seen while on backup power

    logic [1:0] backup_q;
    logic       por_seen_q;
    logic [1:0] bk_set;

    // backup level is a live input, so it is sampled after release, not at reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_seen_q <= 1'b0;
        end else begin
            por_seen_q <= 1'b1;
        end
    end

    assign bk_set[rscs_pkg::BIT_BK_RST] = backup_power_active & (|src_seen_q);
    assign bk_set[rscs_pkg::BIT_BK_POR] = backup_power_active & ~por_seen_q;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_backup
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    backup_q[gi] <= rscs_pkg::BACKUP_POR_VAL[gi];
                end else if (bk_set[gi]) begin
                    backup_q[gi] <= 1'b1;
                end else if (wr_hit_backup && w_strb_q[0]) begin
                    backup_q[gi] <= w_data_q[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // control outputs: registered so the fuses and bits glitch nothing

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_enabled <= 1'b1;
        end else begin
            watchdog_enabled <= fuse_watchdog_on | cause_q[rscs_pkg::BIT_SWDT];
        end
    end

    // an unprogrammed low-power fuse keeps the retention regulator off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            retention_hold_on <= 1'b0;
        end else begin
            retention_hold_on <= cause_q[rscs_pkg::BIT_LVHOLD]
                               & ~low_power_cfg_fuse;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_bias_in_standby <= 1'b0;
        end else begin
            flash_bias_in_standby <= cause_q[rscs_pkg::BIT_FBIAS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read path
    // cause flags survive non-power-on resets so software can read them and
    // clear them afterwards; bus state and outputs here also restart only on aresetn

    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] live_word;

    assign s_axi_arready = ~rvalid_q;

    always_comb begin
        live_word                        = 32'h0000_0000;
        live_word[rscs_pkg::BIT_LV_RST]  = any_active_q;
        live_word[rscs_pkg::BIT_LV_WDT]  = watchdog_enabled;
        live_word[rscs_pkg::BIT_LV_RET]  = retention_hold_on;
        live_word[rscs_pkg::BIT_LV_BIAS] = flash_bias_in_standby;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= rscs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rscs_pkg::RESP_OKAY;
            case (s_axi_araddr)
                rscs_pkg::ADDR_CAUSE: begin
                    rdata_q <= {16'h0000, cause_q};
                end
                rscs_pkg::ADDR_BACKUP: begin
                    rdata_q <= {30'h0000_0000, backup_q};
                end
                rscs_pkg::ADDR_LIVE: begin
                    rdata_q <= live_word;
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= rscs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule

// File: dv/rscs_top_sva.sv
// checker for the reset combiner: reset output, fuse overrides, bus handshakes
// assumes it is bound to rscs_top and sees only its ports
`timescale 1ns/1ps
module rscs_top_chk (
    // clock and power-on reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // reset requests
    input wire logic        master_clear_pin,
    input wire logic        instr_reset_req,
    input wire logic        watchdog_timeout,
    input wire logic        brownout_reset,
    input wire logic        config_mismatch_req,
    input wire logic        trap_conflict_req,
    input wire logic        illegal_opcode_req,
    input wire logic        uninit_wreg_reset,
    // fuses and outputs
    input wire logic        low_power_cfg_fuse,
    input wire logic        fuse_watchdog_on,
    input wire logic        master_system_reset_n,
    input wire logic        watchdog_enabled,
    input wire logic        retention_hold_on
);
    wire any_src = master_clear_pin | instr_reset_req | watchdog_timeout | brownout_reset
                 | config_mismatch_req | trap_conflict_req | illegal_opcode_req
                 | uninit_wreg_reset;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    src_rst_a: assert property (any_src |=> !master_system_reset_n)
        else $error("reset output not active after a source");
    // margin covers the hold stretch after the last source
    rst_free_a: assert property ((!any_src)[*5] |-> master_system_reset_n)
        else $error("reset output stuck active");
    wdt_fuse_a: assert property (fuse_watchdog_on |=> watchdog_enabled)
        else $error("watchdog off while fuse forces it");
    ret_fuse_a: assert property (low_power_cfg_fuse |=> !retention_hold_on)
        else $error("retention hold on while fuse disables it");
    wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data late");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
endmodule

bind rscs_top rscs_top_chk i_chk (.*);

// File: dv/rscs_src_model.sv
// model of the reset sources and core events feeding the combiner
// assumes the bench raises one command bit per event, on clock edges
`timescale 1ns/1ps
module rscs_src_model (
    // clock
    input  wire logic        aclk,
    // bench commands: 7:0 sources, 8 sleep, 9 idle, 10 watchdog clear
    input  wire logic [10:0] ev,
    // requests and events
    output logic [7:0]       req,
    output logic             slp,
    output logic             idl,
    output logic             wclr
);
    // registered so every request starts and ends on an edge, as the core would
    always_ff @(posedge aclk) begin
        req  <= ev[7:0];
        slp  <= ev[8];
        idl  <= ev[9];
        wclr <= ev[10];
    end
endmodule

// File: dv/rscs_tb_top.sv
// testbench: register tasks over axi4-lite, sources pulsed through the model
// assumes the package, design, checker and source model compile first
`timescale 1ns/1ps
module reset_source_combiner_status_tb_top;
    logic        aclk, aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        master_clear_pin, instr_reset_req, watchdog_timeout, brownout_reset;
    logic        config_mismatch_req, trap_conflict_req, illegal_opcode_req;
    logic        uninit_wreg_reset, pwrsav_sleep, pwrsav_idle, watchdog_clear;
    logic        deep_sleep_en, backup_power_active, low_power_cfg_fuse, fuse_watchdog_on;
    logic        master_system_reset_n, watchdog_enabled, retention_hold_on;
    logic        flash_bias_in_standby;
    logic [10:0] ev;
    int          err_total, num_checks;
    localparam logic [1:0] OK = rscs_pkg::RESP_OKAY;
    localparam logic [1:0] SE = rscs_pkg::RESP_SLVERR;
    // flag expected per source, in source index order
    logic [15:0] flag_of [8] = '{16'h0080, 16'h0040, 16'h0010, 16'h0002,
                                 16'h0200, 16'h8000, 16'h4000, 16'h4000};

    rscs_top i_dut (.*);
    rscs_src_model i_src (
        .aclk (aclk),
        .ev   (ev),
        .req  ({uninit_wreg_reset, illegal_opcode_req, trap_conflict_req,
                config_mismatch_req, brownout_reset, watchdog_timeout,
                instr_reset_req, master_clear_pin}),
        .slp  (pwrsav_sleep),
        .idl  (pwrsav_idle),
        .wclr (watchdog_clear)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // address and data offered together; bready held until the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // ready is sampled at the edge itself; each channel drops at the edge that takes it
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
    endtask

    task automatic pulse(input int i);
        @(posedge aclk);
        ev[i] <= 1'b1;
        @(posedge aclk);
        ev[i] <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot, ev} = '0;
        {deep_sleep_en, backup_power_active, low_power_cfg_fuse, fuse_watchdog_on} = '0;
        s_axi_wstrb = 4'hF;
        err_total = 0;
        num_checks = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(rscs_pkg::ADDR_CAUSE, 32'h0003, OK);
        rd(rscs_pkg::ADDR_LIVE, 32'h0, OK);
        for (int i = 0; i < 8; i++) begin
            wr(rscs_pkg::ADDR_CAUSE, 32'h0, OK);
            pulse(i);
            rd(rscs_pkg::ADDR_CAUSE, {16'h0, flag_of[i]}, OK);
        end
        // reset taken while on backup power
        @(posedge aclk) backup_power_active <= 1'b1;
        wr(rscs_pkg::ADDR_BACKUP, 32'h0, OK);
        pulse(rscs_pkg::SRC_TRAP);
        rd(rscs_pkg::ADDR_BACKUP, 32'h1, OK);
        // software sets every flag; no reset must follow
        wr(rscs_pkg::ADDR_CAUSE, 32'hFFFF, OK);
        rd(rscs_pkg::ADDR_CAUSE, 32'hD7FF, OK);
        rd(rscs_pkg::ADDR_LIVE, 32'hE, OK);
        chk({31'h0, master_system_reset_n}, 32'h1);
        @(posedge aclk) low_power_cfg_fuse <= 1'b1;
        rd(rscs_pkg::ADDR_LIVE, 32'hA, OK);
        @(posedge aclk) fuse_watchdog_on <= 1'b1;
        wr(rscs_pkg::ADDR_CAUSE, 32'h0, OK);
        rd(rscs_pkg::ADDR_LIVE, 32'h2, OK);
        wr(rscs_pkg::ADDR_LIVE, 32'hF, OK);
        rd(rscs_pkg::ADDR_LIVE, 32'h2, OK);
        wr(8'h0C, 32'hF, SE);
        rd(8'h0C, 32'h0, SE);
        // power-save events and watchdog flag clearing
        @(posedge aclk) deep_sleep_en <= 1'b1;
        wr(rscs_pkg::ADDR_CAUSE, 32'h10, OK);
        pulse(8);
        rd(rscs_pkg::ADDR_CAUSE, 32'h0408, OK);
        wr(rscs_pkg::ADDR_CAUSE, 32'h10, OK);
        pulse(9);
        rd(rscs_pkg::ADDR_CAUSE, 32'h0004, OK);
        wr(rscs_pkg::ADDR_CAUSE, 32'h10, OK);
        pulse(10);
        rd(rscs_pkg::ADDR_CAUSE, 32'h0, OK);
        // second power-on in mid-run, still on backup power
        @(posedge aclk) aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(rscs_pkg::ADDR_CAUSE, 32'h0003, OK);
        rd(rscs_pkg::ADDR_BACKUP, 32'h2, OK);
        // pin flag set lands on the same edge as the clearing write
        fork
            pulse(rscs_pkg::SRC_PIN);
            begin
                @(posedge aclk);
                wr(rscs_pkg::ADDR_CAUSE, 32'h0, OK);
            end
        join
        rd(rscs_pkg::ADDR_CAUSE, 32'h0080, OK);
        tally_and_finish();
    end
endmodule
